// >>> core/ext_bus_pkg.sv
/*
 Constants for the external memory bus interface: register offsets,
 field positions, segment codes, read maps and bus phases.
 Assumes a 32-bit APB register port with byte addresses.
*/
package ext_bus_pkg;

    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] ADDR_OFS   = 8'h00;
    localparam logic [7:0] WDATA_OFS  = 8'h04;
    localparam logic [7:0] CMD_OFS    = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] CONFIG_OFS = 8'h10;
    localparam logic [7:0] CLKDIV_OFS = 8'h14;

    // ********************************
    // Field positions
    // ********************************
    localparam int CFG0_PAGE   = 0;
    localparam int CFG0_ADDRESS_LATCH_STRETCH   = 1;
    localparam int CFG0_WSA    = 2;
    localparam int CFG0_RD_LO  = 3;
    localparam int CFG1_WSB    = 0;
    localparam int CMD_WRITE   = 0;
    localparam int CMD_DATA    = 1;
    localparam int ST_BUSY     = 0;
    localparam int ST_SEG_ERR  = 1;
    localparam int ST_INTERNAL = 2;
    localparam int ST_EA       = 3;
    localparam int ST_RDATA_LO = 8;
    localparam int CONF_ONE_LO = 8;

    // ********************************
    // Segments, timing, reset values
    // ********************************
    localparam logic [7:0] SEG_00 = 8'h00;
    localparam logic [7:0] SEG_01 = 8'h01;
    localparam logic [7:0] SEG_FE = 8'hFE;
    localparam logic [7:0] SEG_FF = 8'hFF;
    localparam int         STATE_OSC_CYCLES = 2;
    localparam logic [1:0] CFG_SETTLE = 2'h2;
    localparam int         SYNC_W = 33;

    typedef enum logic [1:0] {
        MAP_256K  = 2'b00,
        MAP_128K  = 2'b01,
        MAP_64K   = 2'b10,
        MAP_SPLIT = 2'b11
    } read_map_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ADDR = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_t;

endpackage : ext_bus_pkg

// >>> core/sync_two_flop.sv
/*
 Two flip-flop synchroniser for a group of pin levels.
 Assumes the inputs are levels that stay put longer than two clocks.
*/
`timescale 1ns/1ns
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : sync_two_flop

// >>> core/ext_memory_bus_interface.sv
/*
 External memory bus interface: runs one multiplexed bus cycle per
 software command, with page/non-page mode, wait states and read maps.
 Assumes an APB master, an external address latch and memories that
 answer within the configured states; straps steady around reset.
*/
`timescale 1ns/1ns
// Behaviour
// - A bus state lasts two oscillator cycles; all phases count states.
// - Non-page mode: low port carries low address then data.
// - Page mode: high port carries high address then data.
// - Page mode chosen by the page bit of configuration byte zero.
// - Non-page fetch: one address state, then data state.
// - Latch-stretch bit adds one state to the address phase.
// - Primary wait bit adds one data state in segments FF, FE, 00.
// - Data-only wait bit adds one state to data accesses in segment 01.
// - Only segments 00, 01, FE, FF reach the external bus.
// - Map 00: eighteen address bits, program strobe reads, write strobe writes.
// - Map 01: seventeen bits, bit-seventeen pin freed, space seen twice.
// - Map 10: sixteen bits, both segment pins freed, space seen four times.
// - Map 11: program strobe for code, read strobe for data reads.
// - Map 11: separate code and data segments, each replicated four times.
// - Configuration captured at reset and held during operation.
// - External access pin decides internal or external code fetches.
// - A slower oscillator divider stretches the bus cycle in proportion.
// - Address latch pulses at cycle start while address is driven.
// - External access pin sampled at reset and held until next reset.
module ext_memory_bus_interface #(
    parameter int          CLKDIV_W     = 4,
    parameter logic [15:0] INT_CODE_TOP = 16'h6000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [7:0]  config_byte_zero,
    input  wire logic [7:0]  config_byte_one,
    input  wire logic        external_access_select_n,
    input  wire logic [7:0]  low_multiplex_port_i,
    output logic [7:0]       low_multiplex_port_o,
    output logic             low_multiplex_port_oe,
    input  wire logic [7:0]  high_multiplex_port_i,
    output logic [7:0]       high_multiplex_port_o,
    output logic             high_multiplex_port_oe,
    output logic             address_latch,
    output logic             program_store_strobe_n,
    output logic             read_strobe_n,
    output logic             write_strobe_n,
    output logic             segment_bit_sixteen_o,
    output logic             segment_bit_sixteen_oe,
    output logic             segment_bit_seventeen_o,
    output logic             segment_bit_seventeen_oe
);

    // ********************************
    // Parameter checks
    // ********************************
    if (CLKDIV_W < 1 || CLKDIV_W > 6) begin : g_bad_div
        $error("CLKDIV_W must be 1 to 6");
    end

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        ext_bus_pkg::bus_state_t fsm;
        logic [7:0]          tick;
        logic                left;
        logic [23:0]         addr;
        logic [7:0]          wdata;
        logic                cmd_wr;
        logic                cmd_data;
        logic [7:0]          rdata;
        logic [1:0]          cap;
        logic                seg_err;
        logic                internal;
        logic [7:0]          cfg0;
        logic [7:0]          cfg1;
        logic                ea_n;
        logic [1:0]          settle;
        logic                cfg_ok;
        logic [CLKDIV_W-1:0] clkdiv;
        logic                pready;
        logic [31:0]         prdata;
        logic                pslverr;
        logic                ale;
        logic                program_store_strobe_n_n;
        logic                rd_n;
        logic                wr_n;
        logic [7:0]          p0_o;
        logic [7:0]          p2_o;
        logic                p0_oe;
        logic                p2_oe;
        logic                a16_o;
        logic                a16_oe;
        logic                a17_o;
        logic                a17_oe;
    } state_t;

    state_t                        s_q;
    state_t                        s_d;
    logic [ext_bus_pkg::SYNC_W-1:0] sync_q;
    logic [7:0]                    sy_cfg0;
    logic [7:0]                    sy_cfg1;
    logic                          sy_ea_n;
    logic [7:0]                    sy_p0;
    logic [7:0]                    sy_p2;
    logic [7:0]                    state_last;
    logic                          last;
    logic                          acc;
    logic                          busy;
    logic                          page;
    ext_bus_pkg::read_map_t        rmap;

    // ********************************
    // Decode helpers
    // ********************************
    function automatic logic seg_ok(input logic [7:0] seg);
        seg_ok = (seg == ext_bus_pkg::SEG_00) || (seg == ext_bus_pkg::SEG_01) ||
                 (seg == ext_bus_pkg::SEG_FE) || (seg == ext_bus_pkg::SEG_FF);
    endfunction : seg_ok

    function automatic logic extra_wait(input logic [7:0] seg, input logic data,
                                        input logic wait_state_primary, input logic wait_state_data_only);
        if (seg == ext_bus_pkg::SEG_01) begin
            extra_wait = wait_state_data_only & data;
        end else begin
            extra_wait = wait_state_primary;
        end
    endfunction : extra_wait

    // ********************************
    // Pin synchronisers
    // ********************************
    sync_two_flop #(
        .WIDTH (ext_bus_pkg::SYNC_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({external_access_select_n, config_byte_one, config_byte_zero,
                   high_multiplex_port_i, low_multiplex_port_i}),
        .q       (sync_q)
    );

    assign {sy_ea_n, sy_cfg1, sy_cfg0, sy_p2, sy_p0} = sync_q;
    assign page = s_q.cfg0[ext_bus_pkg::CFG0_PAGE];
    assign rmap = ext_bus_pkg::read_map_t'(s_q.cfg0[ext_bus_pkg::CFG0_RD_LO +: 2]);
    // One state is two oscillator cycles, each stretched by the divider
    assign state_last = 8'(ext_bus_pkg::STATE_OSC_CYCLES * (int'(s_q.clkdiv) + 1) - 1);
    assign last = (s_q.tick == state_last);
    assign acc = psel & penable & s_q.pready;
    assign busy = (s_q.fsm != ext_bus_pkg::BUS_IDLE) || (s_q.cap != 2'h0);

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        s_d = s_q;
        s_d.pready = psel & penable & ~s_q.pready;

        // Straps are caught once, after the synchroniser has filled
        if (!s_q.cfg_ok) begin
            s_d.settle = s_q.settle + 2'h1;
            if (s_q.settle == ext_bus_pkg::CFG_SETTLE) begin
                s_d.cfg0 = sy_cfg0;
                s_d.cfg1 = sy_cfg1;
                s_d.ea_n = sy_ea_n;
                s_d.cfg_ok = 1'b1;
            end
        end

        // Answer is decided one cycle into the access phase
        if (psel & penable & ~s_q.pready) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = '0;
            unique case (paddr)
                ext_bus_pkg::ADDR_OFS:   s_d.prdata[23:0] = s_q.addr;
                ext_bus_pkg::WDATA_OFS:  s_d.prdata[7:0] = s_q.wdata;
                ext_bus_pkg::CMD_OFS: begin
                    s_d.prdata[ext_bus_pkg::CMD_WRITE] = s_q.cmd_wr;
                    s_d.prdata[ext_bus_pkg::CMD_DATA] = s_q.cmd_data;
                    // A start is refused while busy or before straps land
                    s_d.pslverr = pwrite & (busy | ~s_q.cfg_ok);
                end
                ext_bus_pkg::STATUS_OFS: begin
                    s_d.prdata[ext_bus_pkg::ST_BUSY] = busy;
                    s_d.prdata[ext_bus_pkg::ST_SEG_ERR] = s_q.seg_err;
                    s_d.prdata[ext_bus_pkg::ST_INTERNAL] = s_q.internal;
                    s_d.prdata[ext_bus_pkg::ST_EA] = s_q.ea_n;
                    s_d.prdata[ext_bus_pkg::ST_RDATA_LO +: 8] = s_q.rdata;
                end
                ext_bus_pkg::CONFIG_OFS: begin
                    s_d.prdata[7:0] = s_q.cfg0;
                    s_d.prdata[ext_bus_pkg::CONF_ONE_LO +: 8] = s_q.cfg1;
                    s_d.pslverr = pwrite;
                end
                ext_bus_pkg::CLKDIV_OFS: s_d.prdata[CLKDIV_W-1:0] = s_q.clkdiv;
                default:                 s_d.pslverr = 1'b1;
            endcase
        end

        // Pin level at the strobe's last edge leaves the synchroniser two clocks later
        s_d.cap = {s_q.cap[0], 1'b0};
        if (s_q.cap[1]) begin
            s_d.rdata = page ? sy_p2 : sy_p0;
        end

        // Bus cycle sequencing
        if (s_q.fsm != ext_bus_pkg::BUS_IDLE) begin
            s_d.tick = last ? 8'h00 : s_q.tick + 8'h01;
        end
        unique case (s_q.fsm)
            ext_bus_pkg::BUS_IDLE: begin
            end
            ext_bus_pkg::BUS_ADDR: begin
                if (last && s_q.left) begin
                    s_d.left = 1'b0;
                end else if (last) begin
                    s_d.fsm = ext_bus_pkg::BUS_DATA;
                    s_d.ale = 1'b0;
                    s_d.left = extra_wait(s_q.addr[23:16], s_q.cmd_data,
                                          s_q.cfg0[ext_bus_pkg::CFG0_WSA],
                                          s_q.cfg1[ext_bus_pkg::CFG1_WSB]);
                    if (s_q.cmd_wr) begin
                        s_d.wr_n = 1'b0;
                    end else if (rmap == ext_bus_pkg::MAP_SPLIT && s_q.cmd_data) begin
                        s_d.rd_n = 1'b0;
                    end else begin
                        s_d.program_store_strobe_n_n = 1'b0;
                    end
                    // The data side of the multiplex swaps to data
                    if (page) begin
                        s_d.p2_o = s_q.wdata;
                        s_d.p2_oe = s_q.cmd_wr;
                    end else begin
                        s_d.p0_o = s_q.wdata;
                        s_d.p0_oe = s_q.cmd_wr;
                    end
                end
            end
            ext_bus_pkg::BUS_DATA: begin
                if (last && s_q.left) begin
                    s_d.left = 1'b0;
                end else if (last) begin
                    if (!s_q.cmd_wr) begin
                        s_d.cap = 2'h1;
                    end
                    s_d.fsm = ext_bus_pkg::BUS_IDLE;
                    s_d.program_store_strobe_n_n = 1'b1;
                    s_d.rd_n = 1'b1;
                    s_d.wr_n = 1'b1;
                    s_d.p0_oe = 1'b0;
                    s_d.p2_oe = 1'b0;
                end
            end
            default: begin
                s_d.fsm = ext_bus_pkg::BUS_IDLE;
            end
        endcase

        // Register writes take effect at the completing edge only
        if (acc && pwrite && !s_q.pslverr) begin
            unique case (paddr)
                ext_bus_pkg::ADDR_OFS:   s_d.addr = pwdata[23:0];
                ext_bus_pkg::WDATA_OFS:  s_d.wdata = pwdata[7:0];
                ext_bus_pkg::CLKDIV_OFS: s_d.clkdiv = pwdata[CLKDIV_W-1:0];
                ext_bus_pkg::CMD_OFS: begin
                    s_d.cmd_wr = pwdata[ext_bus_pkg::CMD_WRITE];
                    s_d.cmd_data = pwdata[ext_bus_pkg::CMD_WRITE] | pwdata[ext_bus_pkg::CMD_DATA];
                    s_d.seg_err = ~seg_ok(s_q.addr[23:16]);
                    s_d.internal = 1'b0;
                    if (seg_ok(s_q.addr[23:16])) begin
                        if (!s_d.cmd_data && s_q.ea_n && s_q.addr[23:16] == ext_bus_pkg::SEG_FF &&
                            s_q.addr[15:0] < INT_CODE_TOP) begin
                            s_d.internal = 1'b1;
                        end else begin
                            s_d.fsm = ext_bus_pkg::BUS_ADDR;
                            s_d.tick = 8'h00;
                            s_d.left = s_q.cfg0[ext_bus_pkg::CFG0_ADDRESS_LATCH_STRETCH];
                            s_d.ale = 1'b1;
                            s_d.p0_o = s_q.addr[7:0];
                            s_d.p2_o = s_q.addr[15:8];
                            s_d.p0_oe = 1'b1;
                            s_d.p2_oe = 1'b1;
                            s_d.a16_o = s_q.addr[16];
                            s_d.a17_o = s_q.addr[23];
                            s_d.a16_oe = (rmap == ext_bus_pkg::MAP_256K) ||
                                         (rmap == ext_bus_pkg::MAP_128K);
                            s_d.a17_oe = (rmap == ext_bus_pkg::MAP_256K);
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.program_store_strobe_n_n <= 1'b1;
            s_q.rd_n   <= 1'b1;
            s_q.wr_n   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready                   = s_q.pready;
    assign prdata                   = s_q.prdata;
    assign pslverr                  = s_q.pslverr;
    assign low_multiplex_port_o     = s_q.p0_o;
    assign low_multiplex_port_oe    = s_q.p0_oe;
    assign high_multiplex_port_o    = s_q.p2_o;
    assign high_multiplex_port_oe   = s_q.p2_oe;
    assign address_latch            = s_q.ale;
    assign program_store_strobe_n   = s_q.program_store_strobe_n_n;
    assign read_strobe_n            = s_q.rd_n;
    assign write_strobe_n           = s_q.wr_n;
    assign segment_bit_sixteen_o    = s_q.a16_o;
    assign segment_bit_sixteen_oe   = s_q.a16_oe;
    assign segment_bit_seventeen_o  = s_q.a17_o;
    assign segment_bit_seventeen_oe = s_q.a17_oe;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    latch_addr_a: assert property ($rose(s_q.ale) |-> s_q.p0_oe && s_q.p2_oe)
        else $error("latch pulse without address driven");
    addr_len_a: assert property ($rose(s_q.ale) && s_q.clkdiv == '0 && !s_q.cfg0[ext_bus_pkg::CFG0_ADDRESS_LATCH_STRETCH]
                                 |-> s_q.ale[*2] ##1 !s_q.ale)
        else $error("address phase not one state");
    stretch_len_a: assert property ($rose(s_q.ale) && s_q.clkdiv == '0 && s_q.cfg0[ext_bus_pkg::CFG0_ADDRESS_LATCH_STRETCH]
                                    |-> s_q.ale[*4] ##1 !s_q.ale)
        else $error("stretched address phase not two states");
    wait_len_a: assert property ($fell(s_q.program_store_strobe_n_n) && s_q.clkdiv == '0 && s_q.cfg0[ext_bus_pkg::CFG0_WSA] &&
                                 s_q.addr[23:16] != ext_bus_pkg::SEG_01
                                 |-> !s_q.program_store_strobe_n_n[*4] ##1 s_q.program_store_strobe_n_n)
        else $error("primary wait state missing");
    page_port_a: assert property (s_q.fsm == ext_bus_pkg::BUS_DATA && page
                                  |-> s_q.p0_oe && s_q.p2_oe == s_q.cmd_wr)
        else $error("page mode port use wrong");
    nonpage_port_a: assert property (s_q.fsm == ext_bus_pkg::BUS_DATA && !page
                                     |-> s_q.p2_oe && s_q.p0_oe == s_q.cmd_wr)
        else $error("non-page port use wrong");
    cfg_hold_a: assert property (s_q.cfg_ok |=> $stable(s_q.cfg0) && $stable(s_q.cfg1) &&
                                 $stable(s_q.ea_n) && s_q.cfg_ok)
        else $error("configuration changed in operation");
    read_strobe_a: assert property ($fell(s_q.rd_n) |-> rmap == ext_bus_pkg::MAP_SPLIT &&
                                    s_q.cmd_data && !s_q.cmd_wr)
        else $error("read strobe outside split map");
    seg_pins_a: assert property (s_q.fsm != ext_bus_pkg::BUS_IDLE && rmap != ext_bus_pkg::MAP_256K
                                 |-> !s_q.a17_oe && (s_q.a16_oe == (rmap == ext_bus_pkg::MAP_128K)))
        else $error("segment pins not freed");
    bit16_a: assert property ($rose(s_q.a16_oe) |-> s_q.a16_o == s_q.addr[16])
        else $error("bit sixteen pin wrong");

endmodule : ext_memory_bus_interface

// >>> bench/ext_mem_partner.sv
/* Partner model: external memory behind an address latch.
   Assumes the bus block's port, latch and strobe pins on its side. */
`timescale 1ns/1ns
module ext_mem_partner (
    input  wire logic        pclk,
    input  wire logic        page,
    input  wire logic [1:0]  lag,
    input  wire logic [7:0]  lo_o,
    input  wire logic        lo_oe,
    input  wire logic [7:0]  hi_o,
    input  wire logic        hi_oe,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    output logic      [7:0]  lo_i,
    output logic      [7:0]  hi_i,
    output logic      [15:0] addr_q,
    output logic      [7:0]  wbyte_q
);
    // ****
    // Latch, memory and pin levels
    // ****
    logic [7:0] last_lo = 8'h00;
    logic [7:0] last_hi = 8'h00;
    logic [1:0] low_cnt = 2'h0;
    logic [7:0] rbyte;
    logic       drive;
    assign rbyte = addr_q[7:0] ^ addr_q[15:8] ^ 8'h5A;
    // A slow part holds data back for lag cycles of strobe
    assign drive = !rd_n && (low_cnt >= lag);
    // Released ports toggle, so a stale value never looks valid
    assign lo_i = lo_oe ? lo_o : ((drive && !page) ? rbyte : ~last_lo);
    assign hi_i = hi_oe ? hi_o : ((drive && page) ? rbyte : ~last_hi);
    always @(posedge pclk) begin
        last_lo <= lo_i;
        last_hi <= hi_i;
        low_cnt <= rd_n ? 2'h0 : ((low_cnt == 2'h3) ? low_cnt : low_cnt + 2'h1);
        if (ale) begin
            addr_q <= {hi_o, lo_o};
        end
        if (!wr_n) begin
            wbyte_q <= page ? hi_o : lo_o;
        end
    end
endmodule : ext_mem_partner

// >>> bench/ext_memory_bus_interface_tb.sv
/* Testbench: APB tasks run bus cycles under several strap settings.
   Assumes the design package and the partner model compile first. */
`timescale 1ns/1ns
module ext_memory_bus_interface_tb;
    // ****
    // Signals
    // ****
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  config_byte_zero = 8'h00;
    logic [7:0]  config_byte_one = 8'h00;
    logic        external_access_select_n = 1'b0;
    logic        page = 1'b0;
    logic [1:0]  lag = 2'h0;
    logic        clr = 1'b0;
    logic [31:0] cnt = 32'h0;
    logic        pready, pslverr, address_latch, program_store_strobe_n, read_strobe_n, write_strobe_n, err_q;
    logic [31:0] prdata, rd_q;
    logic [7:0]  low_multiplex_port_i, low_multiplex_port_o, high_multiplex_port_i, high_multiplex_port_o, wbyte;
    logic        low_multiplex_port_oe, high_multiplex_port_oe;
    logic        segment_bit_sixteen_o, segment_bit_sixteen_oe, segment_bit_seventeen_o, segment_bit_seventeen_oe;
    logic [15:0] addr_q;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cyc = 0;

    ext_memory_bus_interface dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .config_byte_zero, .config_byte_one, .external_access_select_n,
        .low_multiplex_port_i, .low_multiplex_port_o, .low_multiplex_port_oe,
        .high_multiplex_port_i, .high_multiplex_port_o, .high_multiplex_port_oe,
        .address_latch, .program_store_strobe_n, .read_strobe_n, .write_strobe_n,
        .segment_bit_sixteen_o, .segment_bit_sixteen_oe, .segment_bit_seventeen_o, .segment_bit_seventeen_oe
    );
    ext_mem_partner mem_u (
        .pclk, .page, .lag, .lo_o(low_multiplex_port_o), .lo_oe(low_multiplex_port_oe),
        .hi_o(high_multiplex_port_o), .hi_oe(high_multiplex_port_oe), .ale(address_latch),
        .rd_n(program_store_strobe_n & read_strobe_n), .wr_n(write_strobe_n),
        .lo_i(low_multiplex_port_i), .hi_i(high_multiplex_port_i), .addr_q, .wbyte_q(wbyte)
    );

    // ****
    // Clock, phase counters, timeout
    // ****
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        cnt <= clr ? 32'h0 : cnt + {7'h0, address_latch, 7'h0, !program_store_strobe_n,
                                    7'h0, !read_strobe_n, 7'h0, !write_strobe_n};
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer is taken at the rising edge that sees pready high
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q  = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ****
    // One bus cycle under given straps
    // ****
    task automatic run(input logic [7:0] c0, input logic c1, input logic ext, input logic [23:0] a,
                       input logic [1:0] cmd, input logic [3:0] div, input logic [1:0] lg);
        logic ok, intl, go, rsel;
        int   s, ea, es;
        ok   = a[23:16] inside {8'h00, 8'h01, 8'hFE, 8'hFF};
        intl = cmd == 2'b00 && ext && a[23:16] == 8'hFF && a[15:0] < 16'h6000;
        go   = ok && !intl;
        rsel = c0[4:3] == 2'b11 && cmd == 2'b10;
        s    = 2 * (div + 1);
        ea   = go ? (1 + c0[1]) * s : 0;
        es   = go ? (1 + (c0[2] && a[23:16] != 8'h01) + (a[23:16] == 8'h01 && cmd != 2'b00 && c1)) * s : 0;
        presetn <= 1'b0;
        config_byte_zero <= c0;
        config_byte_one <= {7'h0, c1};
        external_access_select_n <= ext;
        page <= c0[0];
        lag <= lg;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b1, ext_bus_pkg::CLKDIV_OFS, {28'h0, div});
        apb(1'b1, ext_bus_pkg::ADDR_OFS, {8'h00, a});
        apb(1'b1, ext_bus_pkg::WDATA_OFS, {24'h0, a[7:0] ^ 8'hC3});
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        apb(1'b1, ext_bus_pkg::CMD_OFS, {30'h0, cmd});
        do begin
            apb(1'b0, ext_bus_pkg::STATUS_OFS, 32'h0);
        end while (rd_q[0] !== 1'b0);
        chk("phase counts", {ea[7:0], (cmd[0] || rsel) ? 8'h00 : es[7:0], rsel ? es[7:0] : 8'h00,
            cmd[0] ? es[7:0] : 8'h00}, cnt);
        chk("flags", {30'h0, intl, !ok}, {30'h0, rd_q[2:1]});
        if (go && !cmd[0]) begin
            chk("read data", {24'h0, a[7:0] ^ a[15:8] ^ 8'h5A}, {24'h0, rd_q[15:8]});
            chk("latched address", {16'h0, a[15:0]}, {16'h0, addr_q});
        end
        if (go && cmd[0]) begin
            chk("written byte", {24'h0, a[7:0] ^ 8'hC3}, {24'h0, wbyte});
        end
        if (go) begin
            chk("segment pins", {28'h0, c0[4] ? 2'b00 : {1'b1, a[16]}, c0[4:3] == 2'b00 ? {1'b1, a[23]} : 2'b00},
                {28'h0, segment_bit_sixteen_oe, segment_bit_sixteen_o & segment_bit_sixteen_oe,
                segment_bit_seventeen_oe, segment_bit_seventeen_o & segment_bit_seventeen_oe});
        end
        config_byte_zero <= ~c0;
        external_access_select_n <= !ext;
        repeat (4) @(posedge pclk);
        apb(1'b0, ext_bus_pkg::CONFIG_OFS, 32'h0);
        chk("held config", {16'h0, 7'h0, c1, c0}, {16'h0, rd_q[15:0]});
        apb(1'b0, ext_bus_pkg::STATUS_OFS, 32'h0);
        chk("held access select", {31'h0, ext}, {31'h0, rd_q[3]});
        $display("test at address %h done", a);
    endtask : run

    initial begin
        run(8'h00, 1'b0, 1'b0, 24'hFF8123, 2'b00, 4'h0, 2'h0);
        run(8'h0F, 1'b1, 1'b0, 24'h014567, 2'b10, 4'h0, 2'h0);
        run(8'h14, 1'b0, 1'b0, 24'hFE00A5, 2'b11, 4'h1, 2'h0);
        run(8'h18, 1'b0, 1'b0, 24'h001234, 2'b10, 4'h1, 2'h1);
        run(8'h1D, 1'b0, 1'b0, 24'h00BEEF, 2'b00, 4'h0, 2'h0);
        run(8'h00, 1'b0, 1'b0, 24'h020000, 2'b00, 4'h0, 2'h0);
        run(8'h00, 1'b0, 1'b1, 24'hFF5FFF, 2'b00, 4'h0, 2'h0);
        run(8'h08, 1'b0, 1'b1, 24'hFF6000, 2'b00, 4'h0, 2'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped offset error", 32'h1, {31'h0, err_q});
        apb(1'b1, ext_bus_pkg::CONFIG_OFS, 32'h0000FFFF);
        chk("config write error", 32'h1, {31'h0, err_q});
        end_sim();
    end
endmodule : ext_memory_bus_interface_tb
